/* logic/bpm_ctrl.sv */
// Battery power-mode sequencer: mission, brownout and sleep
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - After power-up reset the block settles in mission mode.
// - Supply-good flag drops whenever the analog comparator reports low.
// - Loss of supply selects battery, pulses interrupt, updates status.
// - Mission to brownout never resets or halts the processor.
// - Brownout keeps compute engine and multiplier on; firmware slows them.
// - Brownout keeps debug, serial, EEPROM and clock functions powered.
// - Supply return from any battery mode goes to mission with interrupt.
// - Sleep bit in brownout enters sleep mode.
// - Sleep disconnects digital supply; only retained domain stays powered.
// - Timer, pushbutton, pin rise or receive activity: sleep to brownout.
// - Sleep exits only on supply return, a wake event or a pending self wake.
// - Sleep bit with supply present enters sleep, drops wake, then wakes.
// - Supply return from sleep restarts processor at address zero.
// - Watchdog is held reset while internal wake is low.
module bpm_ctrl
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  // Supply monitors
  input  wire logic                system_supply_pin,
  input  wire logic                analog_supply_ok,
  // Firmware control
  input  wire logic                sleep_request,
  // Wake sources
  input  wire logic                wake_timer_expired,
  input  wire logic                pushbutton_input,
  input  wire logic                wake_pin_a,
  input  wire logic                wake_pin_b,
  input  wire logic                serial_receive_pin,
  input  wire logic                optical_receive_pin,
  // Mode and status
  output bpm_pkg::bpm_mode_t       mode,
  output logic                     supply_good_flag,
  output logic [2:0]               supply_status_field,
  output logic                     supply_irq,
  output logic                     on_battery,
  // Power and restart controls
  output logic                     digital_supply_pin,
  output logic                     compute_engine_en,
  output logic                     multiplier_en,
  output logic                     peripherals_en,
  output logic                     retained_domain_en,
  output logic                     cpu_restart,
  output logic [15:0]              cpu_pc_load,
  output logic                     wake,
  output logic                     wdog_reset
);
  import bpm_pkg::*;

  // ----------------------------------------------------------------
  // Wake event detection
  // ----------------------------------------------------------------
  logic pin_rise;
  logic rx_activity;
  logic wake_event;

  bpm_edge u_edge
  (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .wake_pin_a  (wake_pin_a),
    .wake_pin_b  (wake_pin_b),
    .rx_pins     ({optical_receive_pin, serial_receive_pin}),
    .pin_rise    (pin_rise),
    .rx_activity (rx_activity)
  );

  assign wake_event = wake_timer_expired | pushbutton_input
                    | pin_rise | rx_activity;

  // ----------------------------------------------------------------
  // Mode state
  // ----------------------------------------------------------------
  bpm_mode_t   mode_r;
  bpm_mode_t   mode_nxt;
  logic        good_r;
  logic        good_nxt;
  logic [2:0]  stat_r;
  logic [2:0]  stat_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        wake_r;
  logic        wake_nxt;
  logic        restart_r;
  logic        restart_nxt;
  logic        self_wake_r;
  logic        self_wake_nxt;
  logic [3:0]  settle_r;
  logic [3:0]  settle_nxt;
  logic        sys_ok;

  // Supply counts as present only when both pin and comparator agree
  assign sys_ok = system_supply_pin & analog_supply_ok;

  always_comb
  begin
    mode_nxt      = mode_r;
    good_nxt      = analog_supply_ok;
    stat_nxt      = stat_r;
    irq_nxt       = 1'b0;
    wake_nxt      = wake_r;
    restart_nxt   = 1'b0;
    self_wake_nxt = self_wake_r;
    settle_nxt    = (settle_r != 4'h0) ? settle_r - 4'h1 : 4'h0;
    case (mode_r)
      BPM_MISSION:
      begin
        if (settle_r == 4'h0 && sleep_request)
        begin
          // Sleep with supply present: drop wake, then wake at once
          mode_nxt      = BPM_SLEEP;
          wake_nxt      = 1'b0;
          self_wake_nxt = 1'b1;
          stat_nxt      = BPM_STAT_SLEEP;
        end
        else if (!sys_ok && !good_r)
        begin
          // Processor keeps running; no restart issued
          mode_nxt = BPM_BROWNOUT;
          stat_nxt = BPM_STAT_BATTERY;
          irq_nxt  = 1'b1;
        end
      end
      BPM_BROWNOUT:
      begin
        if (sys_ok)
        begin
          mode_nxt = BPM_MISSION;
          stat_nxt = BPM_STAT_SYSTEM;
          irq_nxt  = 1'b1;
          settle_nxt = BPM_SETTLE_LOAD;
        end
        else if (sleep_request)
        begin
          mode_nxt = BPM_SLEEP;
          wake_nxt = 1'b0;
          stat_nxt = BPM_STAT_SLEEP;
        end
      end
      BPM_SLEEP:
      begin
        // Nothing else leaves sleep
        if (sys_ok && !self_wake_r)
        begin
          mode_nxt    = BPM_MISSION;
          stat_nxt    = BPM_STAT_SYSTEM;
          irq_nxt     = 1'b1;
          wake_nxt    = 1'b1;
          restart_nxt = 1'b1;
          settle_nxt  = BPM_SETTLE_LOAD;
        end
        else if (wake_event || self_wake_r)
        begin
          mode_nxt      = BPM_BROWNOUT;
          stat_nxt      = BPM_STAT_BATTERY;
          wake_nxt      = 1'b1;
          self_wake_nxt = 1'b0;
          restart_nxt   = 1'b1;
        end
      end
      default:
      begin
        mode_nxt = BPM_MISSION;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_r      <= BPM_MISSION;
      good_r      <= 1'b1;
      stat_r      <= BPM_STAT_RESET;
      irq_r       <= 1'b0;
      wake_r      <= 1'b1;
      restart_r   <= 1'b0;
      self_wake_r <= 1'b0;
      settle_r    <= BPM_SETTLE_LOAD;
    end
    else
    begin
      mode_r      <= mode_nxt;
      good_r      <= good_nxt;
      stat_r      <= stat_nxt;
      irq_r       <= irq_nxt;
      wake_r      <= wake_nxt;
      restart_r   <= restart_nxt;
      self_wake_r <= self_wake_nxt;
      settle_r    <= settle_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Power domain controls, registered from next mode
  // ----------------------------------------------------------------
  logic on_bat_r;
  logic on_bat_nxt;
  logic dsup_r;
  logic dsup_nxt;
  logic ce_r;
  logic ce_nxt;
  logic per_r;
  logic per_nxt;

  // Taken from next mode so enables switch in the same cycle as mode
  always_comb
  begin
    on_bat_nxt = (mode_nxt != BPM_MISSION);
    dsup_nxt   = (mode_nxt != BPM_SLEEP);
    ce_nxt     = (mode_nxt != BPM_SLEEP);
    per_nxt    = (mode_nxt != BPM_SLEEP);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      on_bat_r <= 1'b0;
      dsup_r   <= 1'b1;
      ce_r     <= 1'b1;
      per_r    <= 1'b1;
    end
    else
    begin
      on_bat_r <= on_bat_nxt;
      dsup_r   <= dsup_nxt;
      ce_r     <= ce_nxt;
      per_r    <= per_nxt;
    end
  end

  bpm_wdog u_wdog
  (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .wake       (wake_r),
    .wdog_reset (wdog_reset)
  );

  assign mode                = mode_r;
  assign supply_good_flag    = good_r;
  assign supply_status_field = stat_r;
  assign supply_irq          = irq_r;
  assign on_battery          = on_bat_r;
  assign digital_supply_pin  = dsup_r;
  assign compute_engine_en   = ce_r;
  assign multiplier_en       = ce_r;
  assign peripherals_en      = per_r;
  assign retained_domain_en  = 1'b1;
  assign cpu_restart         = restart_r;
  assign cpu_pc_load         = BPM_PC_RESTART;
  assign wake                = wake_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_good_follows: assert property
    (!analog_supply_ok |=> !supply_good_flag)
    else $error("supply good not cleared");
  a_loss_irq: assert property
    (mode == BPM_MISSION && !sleep_request && !sys_ok && !good_r
     |=> mode == BPM_BROWNOUT && supply_irq && on_battery)
    else $error("supply loss missed");
  a_no_restart_bo: assert property
    ($past(mode) == BPM_MISSION && mode == BPM_BROWNOUT |-> !cpu_restart)
    else $error("restart on brownout");
  a_bo_ce_on: assert property
    (mode == BPM_BROWNOUT |-> compute_engine_en && peripherals_en)
    else $error("brownout powered down");
  a_return_msn: assert property
    (mode == BPM_BROWNOUT && sys_ok |=> mode == BPM_MISSION
     && supply_irq && supply_status_field == BPM_STAT_SYSTEM)
    else $error("no return to mission");
  a_sleep_enter: assert property
    (mode == BPM_BROWNOUT && !sys_ok && sleep_request |=>
     mode == BPM_SLEEP && !digital_supply_pin)
    else $error("sleep not entered");
  a_sleep_power: assert property
    (mode == BPM_SLEEP |-> !digital_supply_pin && !compute_engine_en
     && !peripherals_en && retained_domain_en)
    else $error("sleep domains powered");
  a_wake_exit: assert property
    (mode == BPM_SLEEP && !sys_ok && wake_event |=> mode == BPM_BROWNOUT)
    else $error("wake ignored");
  a_sleep_hold: assert property
    (mode == BPM_SLEEP && !sys_ok && !wake_event && !self_wake_r
     |=> mode == BPM_SLEEP)
    else $error("sleep left spuriously");
  a_self_wake: assert property
    (mode == BPM_MISSION && settle_r == 4'h0 && sleep_request |=>
     mode == BPM_SLEEP && !wake ##1 mode == BPM_BROWNOUT ##1 wake)
    else $error("self wake failed");
  a_wdog_hold: assert property
    (!wake |=> wdog_reset)
    else $error("watchdog not held");

  c_brownout: cover property (mode == BPM_MISSION ##1 mode == BPM_BROWNOUT);
  c_sleep:    cover property (mode == BPM_BROWNOUT ##1 mode == BPM_SLEEP);
  c_wake:     cover property (mode == BPM_SLEEP ##1 mode == BPM_BROWNOUT);
  c_restore:  cover property (mode == BPM_SLEEP ##1 mode == BPM_MISSION);

endmodule

`default_nettype wire

/* logic/bpm_edge.sv */
// Rising-edge and activity detector for the wake inputs
`timescale 1ns/1ps
`default_nettype none

module bpm_edge
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Wake inputs
  input  wire logic       wake_pin_a,
  input  wire logic       wake_pin_b,
  input  wire logic [1:0] rx_pins,
  // Detected events
  output logic            pin_rise,
  output logic            rx_activity
);

  logic [1:0] pin_r;
  logic [1:0] pin_nxt;
  logic [1:0] rx_r;
  logic [1:0] rx_nxt;

  always_comb
  begin
    pin_nxt = {wake_pin_b, wake_pin_a};
    rx_nxt  = rx_pins;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_r <= 2'h0;
      rx_r  <= 2'h0;
    end
    else
    begin
      pin_r <= pin_nxt;
      rx_r  <= rx_nxt;
    end
  end

  // Any toggle on a receive line counts as activity
  assign pin_rise    = |({wake_pin_b, wake_pin_a} & ~pin_r);
  assign rx_activity = |(rx_pins ^ rx_r);

endmodule

`default_nettype wire

/* logic/bpm_pkg.sv */
// Package: modes, status codes and timing constants of the power-mode block
package bpm_pkg;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BPM_MISSION  = 2'b00,
    BPM_BROWNOUT = 2'b01,
    BPM_SLEEP    = 2'b10
  } bpm_mode_t;

  // ----------------------------------------------------------------
  // Supply status field codes (three bits)
  // ----------------------------------------------------------------
  localparam logic [2:0] BPM_STAT_SYSTEM  = 3'h0;
  localparam logic [2:0] BPM_STAT_BATTERY = 3'h1;
  localparam logic [2:0] BPM_STAT_SLEEP   = 3'h2;
  localparam logic [2:0] BPM_STAT_RESET   = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BPM_CLK_NS        = 10;
  localparam int BPM_SETTLE_NS     = 100;
  localparam int BPM_SETTLE_CYC    = (BPM_SETTLE_NS + BPM_CLK_NS - 1)
                                     / BPM_CLK_NS;
  localparam logic [3:0] BPM_SETTLE_LOAD = 4'(BPM_SETTLE_CYC);

  // Program counter value on restart from sleep
  localparam logic [15:0] BPM_PC_RESTART = 16'h0000;

  // Wake source count
  localparam int BPM_NWAKE = 4;

endpackage

/* logic/bpm_wdog.sv */
// Watchdog restart control: held in restart while wake is low
`timescale 1ns/1ps
`default_nettype none

module bpm_wdog
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Wake level
  input  wire logic wake,
  // Restart to watchdog
  output logic      wdog_reset
);

  logic wdr_r;
  logic wdr_nxt;

  always_comb
  begin
    wdr_nxt = ~wake;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdr_r <= 1'h1;
    end
    else
    begin
      wdr_r <= wdr_nxt;
    end
  end

  assign wdog_reset = wdr_r;

endmodule

`default_nettype wire

/* testbench/bpm_fw_model.sv */
// Firmware and wake-timer model facing the power-mode block
`timescale 1ns/1ps
`default_nettype none

module bpm_fw_model
(
  // Clock
  input  wire logic               clk_sys,
  // Block state seen by firmware
  input  wire bpm_pkg::bpm_mode_t mode,
  // Firmware and timer outputs
  output logic                    sleep_request,
  output logic                    wake_timer_expired
);
  import bpm_pkg::*;

  initial sleep_request = 1'b0;
  initial wake_timer_expired = 1'b0;

  // ----------------------------------------------------------------
  // Sleep bit
  // ----------------------------------------------------------------
  // Bit held until sleep is seen, then dropped so a wake is not undone
  task automatic request_sleep();
    @(negedge clk_sys);
    sleep_request = 1'b1;
    repeat (20)
    begin
      @(negedge clk_sys);
      if (mode == BPM_SLEEP)
        break;
    end
    sleep_request = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Wake timer
  // ----------------------------------------------------------------
  task automatic run_timer(input int n);
    repeat (n) @(negedge clk_sys);
    wake_timer_expired = 1'b1;
    @(negedge clk_sys);
    wake_timer_expired = 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bpm_pkg::*;

  logic      clk_sys;
  logic      arst_n;
  logic      system_supply_pin;
  logic      analog_supply_ok;
  logic      sleep_request;
  logic      wake_timer_expired;
  logic      pushbutton_input;
  logic      wake_pin_a;
  logic      wake_pin_b;
  logic      serial_receive_pin;
  logic      optical_receive_pin;
  bpm_mode_t mode;
  logic      supply_good_flag;
  logic [2:0] supply_status_field;
  logic      supply_irq;
  logic      on_battery;
  logic      digital_supply_pin;
  logic      compute_engine_en;
  logic      multiplier_en;
  logic      peripherals_en;
  logic      retained_domain_en;
  logic      cpu_restart;
  logic [15:0] cpu_pc_load;
  logic      wake;
  logic      wdog_reset;
  int        failures = 0;
  int        samples_checked = 0;

  bpm_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .system_supply_pin(system_supply_pin),
    .analog_supply_ok(analog_supply_ok), .sleep_request(sleep_request),
    .wake_timer_expired(wake_timer_expired),
    .pushbutton_input(pushbutton_input), .wake_pin_a(wake_pin_a),
    .wake_pin_b(wake_pin_b), .serial_receive_pin(serial_receive_pin),
    .optical_receive_pin(optical_receive_pin), .mode(mode),
    .supply_good_flag(supply_good_flag),
    .supply_status_field(supply_status_field), .supply_irq(supply_irq),
    .on_battery(on_battery), .digital_supply_pin(digital_supply_pin),
    .compute_engine_en(compute_engine_en), .multiplier_en(multiplier_en),
    .peripherals_en(peripherals_en),
    .retained_domain_en(retained_domain_en), .cpu_restart(cpu_restart),
    .cpu_pc_load(cpu_pc_load), .wake(wake), .wdog_reset(wdog_reset));

  bpm_fw_model fw (.clk_sys(clk_sys), .mode(mode),
    .sleep_request(sleep_request), .wake_timer_expired(wake_timer_expired));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic supply(input logic v);
    system_supply_pin = v;
    analog_supply_ok = v;
  endtask

  task automatic finish_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(mode === BPM_MISSION, "rst mode");
    chk(supply_status_field === 3'h0, "rst st");
    chk({supply_irq, cpu_restart} === 2'b00, "rst pulse");
    chk(supply_good_flag === 1'b1 && on_battery === 1'b0, "rst flg");
    chk(wake === 1'b1 && wdog_reset === 1'b0, "rst wdog");
    chk(retained_domain_en === 1'b1, "rst ret");
    chk(cpu_pc_load === 16'h0000, "rst pc");
    $display("t_reset done");
  endtask

  task automatic t_brownout();
    supply(1'b0);
    cyc(1);
    chk(supply_good_flag === 1'b0 && mode === BPM_MISSION, "good");
    cyc(1);
    chk(mode === BPM_BROWNOUT && supply_status_field === 3'h1, "brn");
    chk(supply_irq === 1'b1 && on_battery === 1'b1, "brn irq");
    chk(cpu_restart === 1'b0 && wake === 1'b1, "cpu kept");
    chk({compute_engine_en, multiplier_en} === 2'b11, "ce on");
    chk({peripherals_en, digital_supply_pin} === 2'b11, "per on");
    cyc(1);
    chk(supply_irq === 1'b0, "irq pulse");
    supply(1'b1);
    cyc(1);
    chk(mode === BPM_MISSION && supply_irq === 1'b1, "back");
    chk(supply_status_field === 3'h0 && on_battery === 1'b0, "st");
    $display("t_brownout done");
  endtask

  // Source 0..5: button, pin b, serial, optical, timer, pin a
  task automatic t_sleep_wake(input int src);
    wake_pin_a = 1'b1;
    fw.request_sleep();
    chk(mode === BPM_SLEEP && wake === 1'b0, "slp");
    chk(supply_status_field === 3'h2, "slp st");
    chk({digital_supply_pin, compute_engine_en} === 2'b00, "v off");
    chk(retained_domain_en === 1'b1, "ret");
    cyc(1);
    chk(wdog_reset === 1'b1, "wdog");
    wake_pin_a = 1'b0;
    analog_supply_ok = 1'b1;
    cyc(4);
    chk(mode === BPM_SLEEP, "no exit");
    analog_supply_ok = 1'b0;
    case (src)
      0: pushbutton_input = 1'b1;
      1: wake_pin_b = 1'b1;
      2: serial_receive_pin = ~serial_receive_pin;
      3: optical_receive_pin = ~optical_receive_pin;
      4: fw.run_timer(2);
      default: wake_pin_a = 1'b1;
    endcase
    repeat (8)
    begin
      if (mode === BPM_BROWNOUT)
        break;
      cyc(1);
    end
    chk(mode === BPM_BROWNOUT && wake === 1'b1, "woke");
    chk(cpu_restart === 1'b1 && supply_irq === 1'b0, "wk rst");
    pushbutton_input = 1'b0;
    wake_pin_b = 1'b0;
    cyc(2);
    $display("t_sleep_wake %0d done", src);
  endtask

  task automatic t_return();
    fw.request_sleep();
    supply(1'b1);
    cyc(1);
    chk(mode === BPM_MISSION && supply_irq === 1'b1, "ret");
    chk(cpu_restart === 1'b1 && cpu_pc_load === 16'h0000, "pc");
    chk(digital_supply_pin === 1'b1, "dsup");
    chk(supply_status_field === 3'h0, "s");
    cyc(1);
    chk(cpu_restart === 1'b0 && supply_irq === 1'b0, "pulses");
    // Firmware soft reset after the return; the block reset stands in
    arst_n = 1'b0;
    cyc(1);
    arst_n = 1'b1;
    cyc(1);
    chk(mode === BPM_MISSION && wdog_reset === 1'b0, "soft rst");
    chk(supply_status_field === 3'h0, "soft st");
    chk(cpu_restart === 1'b0 && wake === 1'b1, "soft wk");
    $display("t_return done");
  endtask

  task automatic t_self_sleep();
    cyc(12);
    fw.request_sleep();
    chk(mode === BPM_SLEEP && wake === 1'b0, "self slp");
    cyc(1);
    chk(mode === BPM_BROWNOUT && cpu_restart === 1'b1, "self wk");
    cyc(1);
    chk(mode === BPM_MISSION, "self msn");
    $display("t_self_sleep done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    supply(1'b1);
    pushbutton_input = 1'b0;
    wake_pin_a = 1'b0;
    wake_pin_b = 1'b0;
    serial_receive_pin = 1'b0;
    optical_receive_pin = 1'b0;
    cyc(6);
    arst_n = 1'b1;
    cyc(1);
    t_reset();
    t_brownout();
    for (int s = 0; s < 6; s++)
    begin
      supply(1'b0);
      cyc(3);
      t_sleep_wake(s);
    end
    t_return();
    t_self_sleep();
    finish_test();
  end

  initial
  begin
    #50000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
